// File: hw/pwbs_mirror.sv
`timescale 1ns/100ps
module pwbs_mirror
    import pwbs_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Control and memory side
    pwbs_mir_if.eng m
);
    typedef struct packed {
        logic busy;
        logic [CNT_W-1:0] idx;
        logic rd_d;
        logic [OTP_AW-1:0] raddr_d;
        logic we;
        logic [OTP_AW-1:0] waddr;
        logic [31:0] wdata;
        logic done;
    } pwbs_mir_s;
    pwbs_mir_s r_reg, r_next;

    // Read one word per cycle, write it to RAM two cycles later
    always_comb begin
        r_next = r_reg;
        r_next.done = 1'b0;
        r_next.rd_d = r_reg.busy;
        r_next.raddr_d = r_reg.idx[OTP_AW-1:0];
        r_next.we = r_reg.rd_d;
        r_next.waddr = r_reg.raddr_d;
        if (r_reg.rd_d) begin
            r_next.wdata = m.otp_rdata;
        end
        r_next.done = r_reg.rd_d && !r_reg.busy;
        if (r_reg.busy) begin
            r_next.idx = r_reg.idx + 14'h0001;
            if (r_reg.idx == m.count - 14'h0001) begin
                r_next.busy = 1'b0;
            end
        end else if (m.start) begin
            r_next.busy = 1'b1;
            r_next.idx = '0;
        end
    end

    // State register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    // Engine outputs
    assign m.busy = r_reg.busy;
    assign m.done = r_reg.done;
    assign m.otp_rd = r_reg.busy;
    assign m.otp_addr = r_reg.idx[OTP_AW-1:0];
    assign m.ram_we = r_reg.we;
    assign m.ram_addr = r_reg.waddr;
    assign m.ram_wdata = r_reg.wdata;

    // Helper: writes counted per run
    logic [CNT_W-1:0] wr_cnt;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_cnt <= '0;
        end else if (m.start && !r_reg.busy) begin
            wr_cnt <= '0;
        end else if (r_reg.we) begin
            wr_cnt <= wr_cnt + 14'h0001;
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_read_then_write: assert property (m.otp_rd |=> ##1 m.ram_we)
        else $error("mirror read not written to RAM");
    a_copy_length: assert property (m.done |-> wr_cnt + 14'h0001 == m.count)
        else $error("mirror copied wrong word count");
endmodule // pwbs_mirror

// File: hw/pwbs_seq.sv
// The AHB-Lite interface to the registers was left to the implementer.
`timescale 1ns/100ps
// Function
// - Start runs supply stage, then header fetch or mirroring, then processor hand-over.
// - Supply sequence runs on every power-up and every wake from sleep.
// - Cold-start flag is set by power-up reset and marks cold starts.
// - Cold start releases boot code; wake-up runs hardware mirroring instead.
// - Comparators pick step-down or step-up supply mode automatically.
// - Step-up test first enables converter; else bandgap, core, memory regulators.
// - Then fast crystal starts and a second check rewrites converter mode.
// - Regulator and crystal ready flags are polled until set or timed out.
// - On timeout the ready flags are ignored and the sequence continues.
// - Control bit disables timeout; waits then have no limit.
// - Without timeouts hand-over takes 1.2 to 1.5 ms, set by analog settling.
// - Hardware engine copies OTP words into RAM before the processor runs.
// - Retained word count register feeds the engine and survives sleep.
// - Header word 0x7FFC maps debug port; unprogrammed value keeps it on.
// - Header word 0x7FF8 holds number of words to copy.
// - Radio address at 0x7FD4 two words; 0x7FD0 selects signature algorithm.
// - Calibration word 0x7F78 top half 0xA5A5 means calibrated, zero not.
// - Calibration bits 5..0 flag VCO, crystal, RC, bandgap, RF cap, LNA trims.
// - Sleep clock flag 0x7F74: 0x00 slow crystal, 0xAA precision RC.
// - Package flag 0x7F70 byte 0x00, 0xAA, 0x55 or 0x99 in all bytes.
// - Normal mode only if both application flags hold their keys.
// - Header holds trim CRC at 0x7F0C and IQ trim at 0x7F08.
// - Customer region of 21 words spans 0x7F10 to 0x7F60.
module pwbs_seq
    import pwbs_pkg::*;
#(
    parameter int TMO_CYCLES = SETTLE_TMO_CYC
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Analog comparators and ready flags
    input wire logic low_battery_sense,
    input wire logic high_battery_input,
    input wire logic ldo_ready,
    input wire logic fast_crystal_ready,
    // Sleep control
    input wire logic sleep_req,
    input wire logic wake_req,
    // Power enables
    output logic dcdc_en,
    output logic dcdc_boost,
    output logic bandgap_en,
    output logic core_ldo_en,
    output logic mem_ldo_en,
    output logic fast_crystal_osc_en,
    // Processor release
    output logic cpu_run,
    output logic boot_code_sel,
    output logic debug_port_en,
    // OTP read port
    output logic otp_rd,
    output logic [OTP_AW-1:0] otp_addr,
    input wire logic [31:0] otp_rdata,
    // System RAM write port
    output logic ram_we,
    output logic [OTP_AW-1:0] ram_addr,
    output logic [31:0] ram_wdata
);
    import pwbs_pkg::*;

    localparam logic [TMO_W-1:0] TMO_LAST = TMO_W'(TMO_CYCLES - 1);

    typedef struct packed {
        pwbs_state_e st;
        logic [2:0] idx;
        logic [TMO_W-1:0] tmo;
        logic cold;
        logic tmo_dis;
        logic copy_en;
        logic [CNT_W-1:0] nwords;
        logic dcdc_en;
        logic boost;
        logic bg_en;
        logic core_en;
        logic mem_en;
        logic xtal_en;
        logic cpu_run;
        logic boot_sel;
        logic dbg_en;
        logic app1_ok;
        logic normal;
        logic ldo_tmo;
        logic xtal_tmo;
        logic cal_done;
        logic prec_rc_sel;
        logic [CAL_TRIM_W-1:0] trim_ok;
        logic [1:0] pkg;
        logic mir_start;
        logic dp_wr;
        logic dp_hdr;
        logic dp_iss;
        logic [15:0] dp_addr;
        logic [31:0] hrdata;
    } pwbs_seq_s;
    pwbs_seq_s r_reg, r_next;

    pwbs_mir_if mif ();

    // Header word fetched at each step of the cold-start fetch
    function automatic logic [OTP_AW-1:0] fetch_word(input logic [2:0] i);
        logic [15:0] a;
        case (i)
            3'h0: a = A_DBG;
            3'h1: a = A_APP1;
            3'h2: a = A_APP2;
            3'h3: a = A_CAL;
            3'h4: a = A_SLK;
            default: a = A_PKG;
        endcase
        return a[OTP_AW+1:2];
    endfunction

    // Package option from a replicated byte value
    function automatic logic [1:0] pkg_code(input logic [31:0] w);
        if (w == PKG_B) begin
            return 2'h1;
        end else if (w == PKG_C) begin
            return 2'h2;
        end else if (w == PKG_D) begin
            return 2'h3;
        end
        return 2'h0;
    endfunction

    logic ahb_acc;
    logic otp_free;
    logic fetch_rd;
    logic hdr_rd;
    assign ahb_acc = hsel && htrans[1] && hready;
    assign otp_free = !mif.busy && (r_reg.st != ST_FETCH);
    assign fetch_rd = (r_reg.st == ST_FETCH) && (r_reg.idx <= FETCH_LAST);
    assign hdr_rd = r_reg.dp_hdr && !r_reg.dp_iss && otp_free;

    // Next state: bus data phase, sequencer, bus address phase
    always_comb begin
        logic [31:0] sw;
        sw = '0;
        r_next = r_reg;
        r_next.mir_start = 1'b0;
        r_next.dp_wr = 1'b0;
        // Register writes in the data phase
        if (r_reg.dp_wr) begin
            if (r_reg.dp_addr == A_CTRL) begin
                r_next.tmo_dis = hwdata[CTRL_TMO_DIS];
                r_next.copy_en = hwdata[CTRL_COPY_EN];
            end else if (r_reg.dp_addr == A_COUNT) begin
                r_next.nwords = hwdata[CNT_W-1:0];
            end
        end
        // Header read passes through to the OTP array
        if (r_reg.dp_iss) begin
            r_next.hrdata = otp_rdata;
            r_next.dp_hdr = 1'b0;
            r_next.dp_iss = 1'b0;
        end else if (hdr_rd) begin
            r_next.dp_iss = 1'b1;
        end
        // Start sequencer
        unique case (r_reg.st)
            ST_CHECK: begin
                if (low_battery_sense) begin
                    r_next.dcdc_en = 1'b1;
                    r_next.boost = 1'b1;
                    r_next.st = ST_XTAL;
                end else begin
                    r_next.bg_en = 1'b1;
                    r_next.st = ST_REGS;
                end
            end
            ST_REGS: begin
                if (!r_reg.core_en) begin
                    r_next.core_en = 1'b1;
                end else begin
                    r_next.mem_en = 1'b1;
                    r_next.st = ST_XTAL;
                end
            end
            ST_XTAL: begin
                r_next.xtal_en = 1'b1;
                r_next.boost = low_battery_sense;
                r_next.dcdc_en = low_battery_sense || high_battery_input;
                r_next.tmo = '0;
                r_next.st = ST_WAIT_LDO;
            end
            ST_WAIT_LDO: begin
                if (ldo_ready) begin
                    r_next.tmo = '0;
                    r_next.st = ST_WAIT_XTAL;
                end else if (!r_reg.tmo_dis && r_reg.tmo == TMO_LAST) begin
                    r_next.tmo = '0;
                    r_next.ldo_tmo = 1'b1;
                    r_next.st = ST_WAIT_XTAL;
                end else if (!r_reg.tmo_dis) begin
                    r_next.tmo = r_reg.tmo + 20'h0_0001;
                end
            end
            ST_WAIT_XTAL: begin
                if (fast_crystal_ready || (!r_reg.tmo_dis && r_reg.tmo == TMO_LAST)) begin
                    r_next.xtal_tmo = !fast_crystal_ready;
                    r_next.tmo = '0;
                    r_next.idx = '0;
                    if (r_reg.cold) begin
                        r_next.st = ST_FETCH;
                    end else if (r_reg.copy_en && r_reg.nwords != '0) begin
                        r_next.mir_start = 1'b1;
                        r_next.st = ST_MIRROR;
                    end else begin
                        r_next.boot_sel = 1'b0;
                        r_next.cpu_run = 1'b1;
                        r_next.st = ST_RUN;
                    end
                end else if (!r_reg.tmo_dis) begin
                    r_next.tmo = r_reg.tmo + 20'h0_0001;
                end
            end
            ST_FETCH: begin
                r_next.idx = r_reg.idx + 3'h1;
                case (r_reg.idx)
                    3'h1: r_next.dbg_en = (otp_rdata != DBG_OFF);
                    3'h2: r_next.app1_ok = (otp_rdata == APP1_KEY);
                    3'h3: r_next.normal = r_reg.app1_ok && (otp_rdata == APP2_KEY);
                    3'h4: begin
                        r_next.cal_done = otp_rdata[31:CAL_KEY_LSB] == CAL_KEY;
                        r_next.trim_ok = otp_rdata[CAL_TRIM_W-1:0];
                    end
                    3'h5: r_next.prec_rc_sel = (otp_rdata == SLK_PREC_RC);
                    FETCH_END: r_next.pkg = pkg_code(otp_rdata);
                    default: ;
                endcase
                if (r_reg.idx == FETCH_END) begin
                    r_next.cold = 1'b0;
                    r_next.boot_sel = 1'b1;
                    r_next.cpu_run = 1'b1;
                    r_next.st = ST_RUN;
                end
            end
            ST_MIRROR: begin
                if (mif.done) begin
                    r_next.boot_sel = 1'b0;
                    r_next.cpu_run = 1'b1;
                    r_next.st = ST_RUN;
                end
            end
            ST_RUN: begin
                if (sleep_req) begin
                    r_next.cpu_run = 1'b0;
                    r_next.dcdc_en = 1'b0;
                    r_next.bg_en = 1'b0;
                    r_next.core_en = 1'b0;
                    r_next.mem_en = 1'b0;
                    r_next.xtal_en = 1'b0;
                    r_next.st = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                if (wake_req) begin
                    r_next.ldo_tmo = 1'b0;
                    r_next.xtal_tmo = 1'b0;
                    r_next.st = ST_CHECK;
                end
            end
        endcase
        // Address phase, using values just written
        sw[ST_COLD] = r_next.cold;
        sw[ST_NORMAL] = r_next.normal;
        sw[ST_DBG] = r_next.dbg_en;
        sw[ST_LDO_TMO] = r_next.ldo_tmo;
        sw[ST_XTAL_TMO] = r_next.xtal_tmo;
        sw[ST_MIR_BUSY] = mif.busy;
        sw[ST_CAL_DONE] = r_next.cal_done;
        sw[ST_PREC_RC] = r_next.prec_rc_sel;
        sw[ST_TRIM_LSB +: CAL_TRIM_W] = r_next.trim_ok;
        sw[ST_PKG_LSB +: 2] = r_next.pkg;
        sw[ST_CPU_RUN] = r_next.cpu_run;
        if (ahb_acc) begin
            r_next.dp_addr = haddr[15:0];
            r_next.dp_wr = hwrite;
            r_next.hrdata = '0;
            if (!hwrite && haddr[14:8] == HDR_PAGE && haddr[15] == 1'b0) begin
                r_next.dp_hdr = 1'b1;
            end else if (!hwrite && haddr[15:0] == A_CTRL) begin
                r_next.hrdata[CTRL_TMO_DIS] = r_next.tmo_dis;
                r_next.hrdata[CTRL_COPY_EN] = r_next.copy_en;
            end else if (!hwrite && haddr[15:0] == A_COUNT) begin
                r_next.hrdata[CNT_W-1:0] = r_next.nwords;
            end else if (!hwrite && haddr[15:0] == A_STATUS) begin
                r_next.hrdata = sw;
            end
        end
    end

    // State register; cold flag set by power-up reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            r_reg <= '0;
            r_reg.st <= ST_CHECK;
            r_reg.cold <= 1'b1;
        end else begin
            r_reg <= r_next;
        end
    end

    // Mirroring engine
    assign mif.start = r_reg.mir_start;
    assign mif.count = r_reg.nwords;
    assign mif.otp_rdata = otp_rdata;
    pwbs_mirror u_mirror (
        .hclk(hclk),
        .hresetn(hresetn),
        .m(mif)
    );

    // OTP port: engine, then fetch, then bus
    assign otp_rd = mif.otp_rd || fetch_rd || hdr_rd;
    assign otp_addr = mif.busy ? mif.otp_addr :
        (r_reg.st == ST_FETCH) ? fetch_word(r_reg.idx) : r_reg.dp_addr[OTP_AW+1:2];

    // Outputs
    assign hreadyout = !r_reg.dp_hdr;
    assign hresp = 1'b0;
    assign hrdata = r_reg.hrdata;
    assign dcdc_en = r_reg.dcdc_en;
    assign dcdc_boost = r_reg.boost;
    assign bandgap_en = r_reg.bg_en;
    assign core_ldo_en = r_reg.core_en;
    assign mem_ldo_en = r_reg.mem_en;
    assign fast_crystal_osc_en = r_reg.xtal_en;
    assign cpu_run = r_reg.cpu_run;
    assign boot_code_sel = r_reg.boot_sel;
    assign debug_port_en = r_reg.dbg_en;
    assign ram_we = mif.ram_we;
    assign ram_addr = mif.ram_addr;
    assign ram_wdata = mif.ram_wdata;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_ldo_chain;
        bandgap_en && !core_ldo_en ##1 core_ldo_en && !mem_ldo_en ##1 mem_ldo_en;
    endsequence

    a_regulator_order: assert property (
        r_reg.st == ST_CHECK && !low_battery_sense |=> s_ldo_chain)
        else $error("regulators not enabled in order");
    a_boost_first: assert property (
        r_reg.st == ST_CHECK && low_battery_sense |=> dcdc_en && dcdc_boost && !bandgap_en)
        else $error("step-up path wrong");
    a_crystal_start: assert property ($rose(fast_crystal_osc_en) |->
        r_reg.st == ST_WAIT_LDO && dcdc_boost == $past(low_battery_sense))
        else $error("crystal start or mode check wrong");
    a_timeout_skip: assert property (
        r_reg.st == ST_WAIT_LDO && !ldo_ready && !r_reg.tmo_dis && r_reg.tmo == TMO_LAST
        |=> r_reg.st == ST_WAIT_XTAL && r_reg.ldo_tmo)
        else $error("ready timeout not taken");
    a_no_limit_wait: assert property (
        r_reg.st == ST_WAIT_LDO && r_reg.tmo_dis && !ldo_ready |=> r_reg.st == ST_WAIT_LDO)
        else $error("wait left with timeout disabled");
    a_boot_on_cold: assert property ($rose(cpu_run) |->
        boot_code_sel == $past(r_reg.cold))
        else $error("boot selection wrong");
    a_mirror_on_wake: assert property ($rose(mif.busy) |-> !r_reg.cold && !cpu_run)
        else $error("mirroring on cold start");
    a_header_read: assert property (
        ahb_acc && !hwrite && haddr[14:8] == HDR_PAGE && haddr[15] == 1'b0 && otp_free
        && r_reg.st != ST_WAIT_XTAL && !mif.start |=> !hreadyout ##1 !hreadyout ##1 hreadyout)
        else $error("header read timing wrong");
endmodule // pwbs_seq

// File: inc/pwbs_mir_if.sv
`timescale 1ns/100ps
interface pwbs_mir_if;
    import pwbs_pkg::*;
    logic start;
    logic busy;
    logic done;
    logic [CNT_W-1:0] count;
    logic otp_rd;
    logic [OTP_AW-1:0] otp_addr;
    logic [31:0] otp_rdata;
    logic ram_we;
    logic [OTP_AW-1:0] ram_addr;
    logic [31:0] ram_wdata;
    modport ctl (output start, count, otp_rdata,
        input busy, done, otp_rd, otp_addr, ram_we, ram_addr, ram_wdata);
    modport eng (input start, count, otp_rdata,
        output busy, done, otp_rd, otp_addr, ram_we, ram_addr, ram_wdata);
endinterface

// File: inc/pwbs_pkg.sv
package pwbs_pkg;
    // Own register byte addresses
    localparam logic [15:0] A_CTRL = 16'h0000;
    localparam logic [15:0] A_COUNT = 16'h0004;
    localparam logic [15:0] A_STATUS = 16'h0008;
    // Configuration header byte addresses (read through to the OTP array)
    localparam logic [15:0] A_APP1 = 16'h7F00;
    localparam logic [15:0] A_APP2 = 16'h7F04;
    localparam logic [15:0] A_IQ = 16'h7F08;
    localparam logic [15:0] A_CRC = 16'h7F0C;
    localparam logic [15:0] A_CUST_LO = 16'h7F10;
    localparam logic [15:0] A_CUST_HI = 16'h7F60;
    localparam int CUST_WORDS = 21;
    localparam logic [15:0] A_PKG = 16'h7F70;
    localparam logic [15:0] A_SLK = 16'h7F74;
    localparam logic [15:0] A_CAL = 16'h7F78;
    localparam logic [15:0] A_SIG = 16'h7FD0;
    localparam logic [15:0] A_ADDR = 16'h7FD4;
    localparam logic [15:0] A_LEN = 16'h7FF8;
    localparam logic [15:0] A_DBG = 16'h7FFC;
    localparam logic [6:0] HDR_PAGE = 7'h7F;
    // Header values
    localparam logic [31:0] DBG_OFF = 32'hAAAA_AAAA;
    localparam logic [31:0] APP1_KEY = 32'h1234_A5A5;
    localparam logic [31:0] APP2_KEY = 32'hA5A5_1234;
    localparam logic [15:0] CAL_KEY = 16'hA5A5;
    localparam int CAL_KEY_LSB = 16;
    localparam int CAL_TRIM_W = 6;
    localparam logic [31:0] SLK_PREC_RC = 32'hAAAA_AAAA;
    localparam logic [31:0] PKG_B = 32'hAAAA_AAAA;
    localparam logic [31:0] PKG_C = 32'h5555_5555;
    localparam logic [31:0] PKG_D = 32'h9999_9999;
    // Control and status bit positions
    localparam int CTRL_TMO_DIS = 0;
    localparam int CTRL_COPY_EN = 1;
    localparam int ST_COLD = 0;
    localparam int ST_NORMAL = 1;
    localparam int ST_DBG = 2;
    localparam int ST_LDO_TMO = 3;
    localparam int ST_XTAL_TMO = 4;
    localparam int ST_MIR_BUSY = 5;
    localparam int ST_CAL_DONE = 6;
    localparam int ST_PREC_RC = 7;
    localparam int ST_TRIM_LSB = 8;
    localparam int ST_PKG_LSB = 16;
    localparam int ST_CPU_RUN = 18;
    // Widths
    localparam int OTP_AW = 13;
    localparam int CNT_W = 14;
    localparam int TMO_W = 20;
    // Settle timeout: time and derived cycle count at 200 MHz
    localparam int CLK_MHZ = 200;
    localparam int SETTLE_TMO_US = 250;
    localparam int SETTLE_TMO_CYC = SETTLE_TMO_US * CLK_MHZ;
    // Header fetch sequence
    localparam logic [2:0] FETCH_LAST = 3'h5;
    localparam logic [2:0] FETCH_END = 3'h6;
    // Sequencer states
    typedef enum logic [3:0] {
        ST_CHECK, ST_REGS, ST_XTAL, ST_WAIT_LDO, ST_WAIT_XTAL,
        ST_FETCH, ST_MIRROR, ST_RUN, ST_SLEEP
    } pwbs_state_e;
endpackage

// File: sim/pwbs_seq_tb.sv
`timescale 1ns/100ps
module pwbs_seq_tb;
    import pwbs_pkg::*;
    localparam int TMO = 8;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic low_battery_sense = 1'b0;
    logic high_battery_input = 1'b1;
    logic ldo_ready = 1'b0;
    logic fast_crystal_ready = 1'b1;
    logic sleep_req = 1'b0;
    logic wake_req = 1'b0;
    logic [31:0] otp_rdata = 32'h0;
    logic hreadyout, hresp, dcdc_en, dcdc_boost, bandgap_en, core_ldo_en, mem_ldo_en;
    logic fast_crystal_osc_en, cpu_run, boot_code_sel, debug_port_en, otp_rd, ram_we;
    logic [OTP_AW-1:0] otp_addr, ram_addr;
    logic [31:0] hrdata, ram_wdata, st;
    logic [31:0] mem [0:8191];
    logic [63:0] rd_q[$];
    logic [63:0] ram_q[$];
    logic rd_ph = 1'b0;
    int failures = 0;
    int n_tests = 0;
    int seed = 32'h12e5;
    int n;
    logic [15:0] hdr [12] = '{A_APP1, A_APP2, A_IQ, A_CRC, A_CUST_HI, A_PKG, A_SLK, A_CAL,
        A_SIG, A_ADDR, A_LEN, A_DBG};

    // Clock at 200 MHz
    always #2.5 hclk = ~hclk;

    pwbs_seq #(.TMO_CYCLES(TMO)) pwbs_seq_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .low_battery_sense(low_battery_sense), .high_battery_input(high_battery_input),
        .ldo_ready(ldo_ready), .fast_crystal_ready(fast_crystal_ready),
        .sleep_req(sleep_req), .wake_req(wake_req), .dcdc_en(dcdc_en),
        .dcdc_boost(dcdc_boost), .bandgap_en(bandgap_en), .core_ldo_en(core_ldo_en),
        .mem_ldo_en(mem_ldo_en), .fast_crystal_osc_en(fast_crystal_osc_en),
        .cpu_run(cpu_run), .boot_code_sel(boot_code_sel), .debug_port_en(debug_port_en),
        .otp_rd(otp_rd), .otp_addr(otp_addr), .otp_rdata(otp_rdata), .ram_we(ram_we),
        .ram_addr(ram_addr), .ram_wdata(ram_wdata));

    // Synchronous OTP array; the data bus drifts when no read is made
    always @(posedge hclk) otp_rdata <= otp_rd ? mem[otp_addr] : ~otp_rdata;

    task automatic compare(input logic [63:0] got, input logic [63:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic conclude;
        $display("Comparisons %0d, mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Read data and RAM writes are checked against the oldest note
    always @(posedge hclk) begin
        if (rd_ph && hreadyout)
            compare(hrdata, rd_q.size() ? rd_q.pop_front() : 64'hx);
        if (ram_we)
            compare({ram_addr, ram_wdata}, ram_q.size() ? ram_q.pop_front() : 64'hx);
        if (hreadyout) rd_ph <= hsel && htrans[1] && !hwrite;
    end

    // One single AHB-Lite transfer, waiting on hready in both phases
    task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
    endtask

    task automatic rd(input logic [31:0] a, input logic [31:0] exp);
        rd_q.push_back(64'(exp));
        ahb(1'b0, a, 32'h0);
    endtask

    task automatic wait_run(input logic v);
        for (int k = 0; k < 400 && cpu_run !== v; k++) @(posedge hclk);
    endtask

    // Sleep from run, then wake
    task automatic nap;
        sleep_req <= 1'b1;
        @(posedge hclk);
        sleep_req <= 1'b0;
        wait_run(1'b0);
        wake_req <= 1'b1;
        @(posedge hclk);
        wake_req <= 1'b0;
    endtask

    // Main sequence
    initial begin
        for (int i = 0; i < 12; i++) mem[hdr[i][14:2]] = $random(seed);
        mem[A_APP1[14:2]] = APP1_KEY;
        mem[A_APP2[14:2]] = APP2_KEY;
        mem[A_DBG[14:2]] = DBG_OFF;
        mem[A_SLK[14:2]] = SLK_PREC_RC;
        mem[A_PKG[14:2]] = PKG_D;
        mem[A_CAL[14:2]] = {CAL_KEY, 10'h0, 6'($random(seed))};
        n = ($random(seed) & 3) + 1;
        for (int i = 0; i < n; i++) mem[i] = $random(seed);
        repeat (10) @(posedge hclk);
        compare({hreadyout, cpu_run, bandgap_en, dcdc_en, otp_rd, ram_we}, 6'h20);
        hresetn <= 1'b1;
        wait_run(1'b1);
        compare(cpu_run, 1'b1);
        compare({boot_code_sel, debug_port_en, bandgap_en, core_ldo_en, mem_ldo_en,
            fast_crystal_osc_en, dcdc_en}, 7'h5f);
        st = {13'h0, 1'b1, 2'h3, 2'h0, mem[A_CAL[14:2]][5:0], 8'hca};
        rd(32'(A_STATUS), st);
        for (int i = 0; i < 12; i++) begin
            rd(32'(hdr[i]), mem[hdr[i][14:2]]);
        end
        ahb(1'b1, 32'(A_STATUS), 32'hffff_ffff);
        rd(32'(A_STATUS), st);
        rd(32'h0000_0100, 32'h0);
        ahb(1'b1, 32'(A_COUNT), 32'(n));
        rd(32'(A_COUNT), 32'(n));
        ahb(1'b1, 32'(A_CTRL), 32'h2);
        rd(32'(A_CTRL), 32'h2);
        ldo_ready <= 1'b1;
        for (int i = 0; i < n; i++) ram_q.push_back(64'({13'(i), mem[i]}));
        nap();
        wait_run(1'b1);
        compare({cpu_run, boot_code_sel, 32'(ram_q.size())}, 34'h2_0000_0000);
        // Wake with the timeout off and the step-up comparator passing
        ahb(1'b1, 32'(A_CTRL), 32'h3);
        low_battery_sense <= 1'b1;
        ldo_ready <= 1'b0;
        for (int i = 0; i < n; i++) ram_q.push_back(64'({13'(i), mem[i]}));
        nap();
        repeat (40) @(posedge hclk);
        compare(cpu_run, 1'b0);
        ldo_ready <= 1'b1;
        wait_run(1'b1);
        compare({cpu_run, dcdc_en, boot_code_sel, 32'(ram_q.size())},
            35'h6_0000_0000);
        rd(32'(A_COUNT), 32'(n));
        // Wake with copying off: plain hand-over, never to boot code
        ahb(1'b1, 32'(A_CTRL), 32'h0);
        nap();
        wait_run(1'b1);
        compare({cpu_run, boot_code_sel}, 2'h2);
        conclude();
    end

    // Watchdog against a hang
    initial begin
        repeat (20000) @(posedge hclk);
        failures++;
        conclude();
    end
endmodule // pwbs_seq_tb
